// ===== common/wdr_defs.svh
`ifndef WDR_DEFS_SVH
`define WDR_DEFS_SVH
// register byte offsets
`define WDR_OFF_RESTART   8'h0C
`define WDR_OFF_STATUS    8'h10
`define WDR_OFF_CLEAR     8'h14
`define WDR_OFF_PARAM5    8'hE4
`define WDR_OFF_PARAM4    8'hE8
`define WDR_OFF_PARAM3    8'hEC
`define WDR_OFF_PARAM2    8'hF0
`define WDR_OFF_PARAM1    8'hF4
`define WDR_OFF_VERSION   8'hF8
`define WDR_OFF_TYPE      8'hFC
// restart key field
`define WDR_KEY_MSB       7
`define WDR_KEY_LSB       0
`define WDR_KEY           8'h76
// status and clear bit position
`define WDR_STAT_BIT      0
// reset and fixed read values
`define WDR_RST_ZERO      32'h0000_0000
`define WDR_RST_PARAM2    32'h0000_FFFF
`define WDR_RST_COUNT     32'h0000_FFFF
// version: ascii digits then '*', value arbitrary
`define WDR_VERSION_WORD  32'h3030_312A
// type code, value arbitrary
`define WDR_TYPE_WORD     32'h0000_0001
// reset pulse: two cycles shifted left by the length select
`define WDR_PULSE_BASE    9'h002
`endif

// ===== common/wdr_pkg.sv
package wdr_pkg;
    // response to a timeout
    typedef enum logic {
        wdr_resp_reset,
        wdr_resp_irq_first
    } wdr_resp_t;

    // system reset pulse sequencer
    typedef enum logic {
        wdr_rst_idle,
        wdr_rst_pulse
    } wdr_rst_st_t;
endpackage : wdr_pkg

// ===== common/wdr_cnt_if.sv
`timescale 1ns/1ps
interface wdr_cnt_if #(parameter int CNT_W = 32);
    logic             restart;
    logic             enable;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] count;
    logic             timeout;

    modport ctl (output restart, output enable, output period, input count, input timeout);
    modport cnt (input restart, input enable, input period, output count, output timeout);
endinterface : wdr_cnt_if

// ===== design/wdr_counter.sv
`timescale 1ns/1ps
`include "wdr_defs.svh"
module wdr_counter
    import wdr_pkg::*;
#(
    parameter int CNT_W = 32
)(
    input wire logic clk,
    input wire logic rst,
    wdr_cnt_if.cnt   cif
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] period_r;

    // expiry seen while running; a kick in the same cycle wins
    assign cif.timeout = cif.enable && (count_r == '0) && !cif.restart;
    assign cif.count   = count_r;

    // period is latched only on a kick, so a new setting waits for one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            period_r <= CNT_W'(`WDR_RST_COUNT);
        else if (cif.restart)
            period_r <= cif.period; // [R9]
    end

    // down-counter; wraps to the latched period after expiry
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count_r <= CNT_W'(`WDR_RST_COUNT);
        else if (cif.restart)
            count_r <= cif.period; // [R9]
        else if (cif.enable)
        begin
            if (count_r == '0)
                count_r <= period_r;
            else
                count_r <= count_r - CNT_W'(1);
        end
    end

    period_wrap_a: assert property (@(posedge clk) disable iff (rst) // [R9]
        cif.timeout |=> count_r == $past(period_r))
        else $error("counter did not wrap to latched period");
endmodule : wdr_counter

// ===== design/wdr_regs.sv
`timescale 1ns/1ps
`include "wdr_defs.svh"
// Behaviour
// (R1) only key 0x76 in low byte kicks
// (R2) accepted kick also clears pending interrupt
// (R3) restart register always reads zero
// (R4) status bit 0 shows pending interrupt
// (R5) clear access drops interrupt, counter untouched
// (R6) version word is ascii digits plus asterisk
// (R7) software writes reserved bits zero, ignores them
// (R8) interrupt-first: second uncleared timeout resets system
// (R9) kick reloads from current period, latched then
// (R10) wrong key changes neither counter nor interrupt
module wdr_regs
    import wdr_pkg::*;
#(
    parameter int          CNT_W        = 32,
    parameter logic [31:0] VERSION_WORD = `WDR_VERSION_WORD,
    parameter logic [31:0] TYPE_WORD    = `WDR_TYPE_WORD,
    parameter logic [31:0] PARAM1_WORD  = `WDR_RST_ZERO,
    parameter logic [31:0] PARAM2_WORD  = `WDR_RST_PARAM2,
    parameter logic [31:0] PARAM3_WORD  = `WDR_RST_ZERO,
    parameter logic [31:0] PARAM4_WORD  = `WDR_RST_ZERO,
    parameter logic [31:0] PARAM5_WORD  = `WDR_RST_ZERO,
    parameter bit          IRQ_ACT_HIGH = 1'b1
)(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             wdt_enable,
    input  wire wdr_resp_t        resp_mode,
    input  wire logic [CNT_W-1:0] timeout_period,
    input  wire logic [2:0]       pulse_len_sel,
    output logic [CNT_W-1:0]      count_value,
    output logic                  irq,
    output logic                  sys_reset
);
    wdr_cnt_if #(.CNT_W(CNT_W)) cif ();

    logic        irq_r;
    logic        sys_reset_r;
    logic [31:0] prdata_r;
    logic [8:0]  pulse_cnt_r;
    wdr_rst_st_t rst_st_r;

    logic        setup_rd;
    logic        access;
    logic        mapped;
    logic        kick;
    logic        wrong_key;
    logic        clear_acc;
    logic        to_irq;
    logic        to_reset;

    wdr_counter #(.CNT_W(CNT_W)) u_counter (
        .clk (clk),
        .rst (rst),
        .cif (cif)
    );

    // address decode; reads are captured in setup so data comes from a flop
    always_comb
    begin
        unique case (paddr)
            `WDR_OFF_RESTART, `WDR_OFF_STATUS, `WDR_OFF_CLEAR,
            `WDR_OFF_PARAM5, `WDR_OFF_PARAM4, `WDR_OFF_PARAM3,
            `WDR_OFF_PARAM2, `WDR_OFF_PARAM1, `WDR_OFF_VERSION,
            `WDR_OFF_TYPE: mapped = 1'b1;
            default:       mapped = 1'b0;
        endcase
    end

    assign setup_rd = psel && !penable && !pwrite;
    assign access   = psel && penable;
    assign pready   = 1'b1;
    assign pslverr  = access && !mapped; // unmapped offsets answer an error

    // key check on the low byte only; upper bits are don't care
    assign kick      = access && pwrite && (paddr == `WDR_OFF_RESTART)
                       && (pwdata[`WDR_KEY_MSB:`WDR_KEY_LSB] == `WDR_KEY); // [R1]
    assign wrong_key = access && pwrite && (paddr == `WDR_OFF_RESTART) && !kick; // [R10]
    // any access, read or write, to the clear register acks the interrupt
    assign clear_acc = access && (paddr == `WDR_OFF_CLEAR); // [R5]

    // counter hookup; only a good key reaches the counter
    assign cif.restart = kick; // [R1] [R10]
    assign cif.enable  = wdt_enable;
    assign cif.period  = timeout_period; // [R9]
    assign count_value = cif.count;

    // timeout response split by mode
    assign to_irq   = cif.timeout && (resp_mode == wdr_resp_irq_first); // [R8]
    assign to_reset = cif.timeout && ((resp_mode == wdr_resp_reset) || irq_r); // [R8]

    // pending interrupt; a timeout in the clearing cycle still sets it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_r <= 1'b0;
        else if (to_irq)
            irq_r <= 1'b1; // [R8]
        else if (kick || clear_acc)
            irq_r <= 1'b0; // [R2] [R5]
    end

    assign irq = irq_r ^ !IRQ_ACT_HIGH; // polarity on the pin only

    // reset pulse sequencer; a timeout during a pulse does not stretch it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rst_st_r    <= wdr_rst_idle;
            sys_reset_r <= 1'b0;
            pulse_cnt_r <= '0;
        end
        else
        begin
            unique case (rst_st_r)
                wdr_rst_idle:
                begin
                    if (to_reset)
                    begin
                        rst_st_r    <= wdr_rst_pulse; // [R8]
                        sys_reset_r <= 1'b1;
                        pulse_cnt_r <= (`WDR_PULSE_BASE << pulse_len_sel) - 9'h001;
                    end
                end
                wdr_rst_pulse:
                begin
                    if (pulse_cnt_r == 9'h000)
                    begin
                        rst_st_r    <= wdr_rst_idle;
                        sys_reset_r <= 1'b0;
                    end
                    else
                        pulse_cnt_r <= pulse_cnt_r - 9'h001;
                end
            endcase
        end
    end

    assign sys_reset = sys_reset_r;

    // read data, captured in setup phase and held through access
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prdata_r <= `WDR_RST_ZERO;
        else if (setup_rd)
        begin
            unique case (paddr)
                `WDR_OFF_RESTART: prdata_r <= `WDR_RST_ZERO; // [R3]
                `WDR_OFF_STATUS:  prdata_r <= {31'h0000_0000, irq_r}; // [R4]
                `WDR_OFF_CLEAR:   prdata_r <= `WDR_RST_ZERO;
                `WDR_OFF_PARAM5:  prdata_r <= PARAM5_WORD;
                `WDR_OFF_PARAM4:  prdata_r <= PARAM4_WORD;
                `WDR_OFF_PARAM3:  prdata_r <= PARAM3_WORD;
                `WDR_OFF_PARAM2:  prdata_r <= PARAM2_WORD;
                `WDR_OFF_PARAM1:  prdata_r <= PARAM1_WORD;
                `WDR_OFF_VERSION: prdata_r <= VERSION_WORD; // [R6]
                `WDR_OFF_TYPE:    prdata_r <= TYPE_WORD;
                default:          prdata_r <= `WDR_RST_ZERO;
            endcase
        end
    end

    assign prdata = prdata_r;

    restart_key_a: assert property (@(posedge clk) disable iff (rst) // [R1]
        kick |=> cif.count == $past(timeout_period))
        else $error("keyed restart did not reload counter");

    wrong_key_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        wrong_key && !cif.timeout |=> irq_r == $past(irq_r))
        else $error("wrong key disturbed interrupt");

    wrong_cnt_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        wrong_key && !wdt_enable |=> cif.count == $past(cif.count))
        else $error("wrong key disturbed counter");

    kick_clear_a: assert property (@(posedge clk) disable iff (rst) // [R2]
        kick |=> !irq_r)
        else $error("restart left interrupt pending");

    restart_zero_a: assert property (@(posedge clk) disable iff (rst) // [R3]
        setup_rd && paddr == `WDR_OFF_RESTART |=> prdata == 32'h0000_0000)
        else $error("restart register read nonzero");

    status_read_a: assert property (@(posedge clk) disable iff (rst) // [R4]
        setup_rd && paddr == `WDR_OFF_STATUS |=> prdata == {31'h0000_0000, $past(irq_r)})
        else $error("status bit does not match pending interrupt");

    eoi_clear_a: assert property (@(posedge clk) disable iff (rst) // [R5]
        clear_acc && !cif.timeout |=> !irq_r)
        else $error("clear access left interrupt pending");

    eoi_count_a: assert property (@(posedge clk) disable iff (rst) // [R5]
        clear_acc && wdt_enable && cif.count != '0 |=>
        cif.count == $past(cif.count) - CNT_W'(1))
        else $error("clear access disturbed counter");

    version_read_a: assert property (@(posedge clk) disable iff (rst) // [R6]
        setup_rd && paddr == `WDR_OFF_VERSION |=>
        prdata == VERSION_WORD && prdata[7:0] == 8'h2A)
        else $error("version word wrong");

    second_timeout_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        cif.timeout && irq_r && rst_st_r == wdr_rst_idle |=> sys_reset && irq_r)
        else $error("second timeout gave no system reset");

    first_timeout_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        cif.timeout && !irq_r && resp_mode == wdr_resp_irq_first
        && rst_st_r == wdr_rst_idle |=> irq_r && !sys_reset)
        else $error("first timeout did not raise interrupt only");
endmodule : wdr_regs

// ===== sim/wdr_apb_host.sv
`timescale 1ns/1ps
module wdr_apb_host (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end
    // one transfer; only the low byte carries data, reserved bits zero
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        psel   = 1'b1;
        pwrite = w;
        paddr  = a;
        pwdata = {24'h00_0000, d};
        @(posedge clk);
        #1;
        penable = 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        r = prdata;
        // a missing ready spoils the error flag so the caller's compare trips
        e = (pready === 1'b1) ? pslverr : 1'bx;
        #1;
        // idle bus shows inverted values so stale ones never pass
        psel    = 1'b0;
        penable = 1'b0;
        paddr   = ~paddr;
        pwdata  = ~pwdata;
    endtask : xfer
endmodule : wdr_apb_host

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`include "wdr_defs.svh"
module tb_top;
    import wdr_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, en, irq, srst, e;
    logic [7:0]  paddr, k;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] per, cnt, c0;
    logic [2:0]  sel;
    wdr_resp_t   mode;
    int          bad_count, comparisons, n;
    logic [7:0]  offs [11] = '{`WDR_OFF_RESTART, `WDR_OFF_STATUS, `WDR_OFF_CLEAR,
        `WDR_OFF_PARAM5, `WDR_OFF_PARAM4, `WDR_OFF_PARAM3, `WDR_OFF_PARAM2,
        `WDR_OFF_PARAM1, `WDR_OFF_VERSION, `WDR_OFF_TYPE, 8'h20};
    wdr_regs #(.CNT_W(16)) u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdt_enable(en), .resp_mode(mode), .timeout_period(per),
        .pulse_len_sel(sel), .count_value(cnt), .irq(irq), .sys_reset(srst));
    wdr_apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // read value of each place after reset
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            `WDR_OFF_PARAM2:  return `WDR_RST_PARAM2;
            `WDR_OFF_VERSION: return `WDR_VERSION_WORD;
            `WDR_OFF_TYPE:    return `WDR_TYPE_WORD;
            default:          return `WDR_RST_ZERO;
        endcase
    endfunction : exp_rd
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x)
        begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask : chk
    // bounded wait for irq (s=0) or system reset (s=1)
    task automatic wait_for(input logic s);
        n = 0;
        while (((s ? srst : irq) !== 1'b1) && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(s ? srst : irq), 32'h1);
    endtask : wait_for
    task automatic pulse();
        n = 0;
        while (srst === 1'b1 && n < 600)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(n), 32'(2 << sel));
    endtask : pulse
    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // run needs a few hundred cycles; far longer means a hang
    initial
    begin
        #300_000;
        bad_count++;
        results();
    end
    initial
    begin
        rst = 1'b1;
        en = 1'b0;
        mode = wdr_resp_irq_first;
        per = 16'h0010;
        sel = 3'h1;
        bad_count = 0;
        comparisons = 0;
        void'($urandom(86));
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        // every place from reset, last one unmapped
        foreach (offs[i])
        begin
            u_host.xfer(1'b0, offs[i], 8'h00, r, e);
            chk(r, exp_rd(offs[i]));
            chk(32'(e), 32'(i == 10));
        end
        u_host.xfer(1'b0, `WDR_OFF_VERSION, 8'h00, r, e);
        chk({r[31:8] & 24'hF0_F0F0, r[7:0]}, 32'h3030_302A);
        // stopped counter: a wrong key must not reload it either
        u_host.xfer(1'b1, `WDR_OFF_RESTART, 8'h67, r, e);
        chk(32'(cnt), 32'(16'(`WDR_RST_COUNT)));
        en = 1'b1;
        // random wrong keys: counter keeps counting down
        repeat (3)
        begin
            k = 8'($urandom_range(0, 255));
            if (k == `WDR_KEY)
                k = 8'h00;
            c0 = cnt;
            u_host.xfer(1'b1, `WDR_OFF_RESTART, k, r, e);
            chk(32'(cnt), 32'(c0 - 16'h0003));
        end
        u_host.xfer(1'b1, `WDR_OFF_RESTART, `WDR_KEY, r, e);
        chk(32'(cnt), 32'(per));
        u_host.xfer(1'b0, `WDR_OFF_RESTART, 8'h00, r, e);
        chk(r, 32'h0000_0000);
        wait_for(1'b0);
        chk(32'(cnt), 32'h0010);
        per = 16'h0020;
        u_host.xfer(1'b0, `WDR_OFF_STATUS, 8'h00, r, e);
        chk(r, 32'h0000_0001);
        u_host.xfer(1'b1, `WDR_OFF_RESTART, 8'h75, r, e);
        chk(32'(irq), 32'h1);
        u_host.xfer(1'b0, `WDR_OFF_CLEAR, 8'h00, r, e);
        chk(32'(irq), 32'h0);
        chk(32'(cnt), 32'h0007);
        // new period not used on wrap, only after a kick
        wait_for(1'b0);
        chk(32'(cnt), 32'h0010);
        u_host.xfer(1'b1, `WDR_OFF_RESTART, `WDR_KEY, r, e);
        chk(32'(irq), 32'h0);
        chk(32'(cnt), 32'(per));
        wait_for(1'b0);
        chk(32'(srst), 32'h0);
        wait_for(1'b1);
        pulse();
        // clear by a write too; counter runs on: period less pulse and transfer
        u_host.xfer(1'b1, `WDR_OFF_CLEAR, 8'h00, r, e);
        chk(32'(irq), 32'h0);
        chk(32'(cnt), 32'(per - 16'(2 << sel) - 16'h0003));
        mode = wdr_resp_reset;
        repeat (2)
        begin
            sel = 3'($urandom_range(0, 3));
            u_host.xfer(1'b1, `WDR_OFF_RESTART, `WDR_KEY, r, e);
            wait_for(1'b1);
            chk(32'(irq), 32'h0);
            pulse();
        end
        results();
    end
endmodule : tb_top
